// file: hw/dcf_map.svh
// Constants for the daisy-chained fault line block
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH
// ==========================================
// Clock and timing
`define DCF_CLK_MHZ 250
`define DCF_PULSE_WIDTH_US 500
`define DCF_SHORT_FILTER_US 300
`define DCF_LONG_FILTER_US 3500
`define DCF_PERIOD0_MS 4
`define DCF_PERIOD1_MS 8
`define DCF_PERIOD2_MS 32
`define DCF_PERIOD3_MS 128
`define DCF_US_PER_MS 1000
// Loss limit is 12/10 of the period
`define DCF_LOSS_NUM 12
`define DCF_LOSS_DEN 10
`define DCF_CNT_W 32
// ==========================================
// Register map (byte addresses)
`define DCF_ADDR_CTRL 8'h00
`define DCF_ADDR_FAIL 8'h04
`define DCF_ADDR_STAT 8'h08
`define DCF_ADDR_W 8
`define DCF_LANES 4
`define DCF_LANE_W 8
// CTRL fields
`define DCF_CTRL_PTE 0
`define DCF_CTRL_FRE 1
`define DCF_CTRL_TOP 2
`define DCF_CTRL_FORCE 3
`define DCF_CTRL_PSEL_LO 4
`define DCF_CTRL_PSEL_HI 6
// FAIL/STAT fields
`define DCF_FAIL_INT 0
`define DCF_FAIL_EXT 1
`define DCF_STAT_STATIC 0
`define DCF_STAT_LOSS 1
`define DCF_STAT_OUT 2
`define DCF_STAT_IN 3
`define DCF_STAT_PST_LO 4
`define DCF_STAT_PST_HI 5
// Two-bit state codes in STAT
`define DCF_PCODE_CYCLIC 2'h0
`define DCF_PCODE_NORMAL 2'h1
`define DCF_PCODE_SLEEP 2'h2
`define DCF_PCODE_SILENT 2'h3
`define DCF_CTRL_RST 32'h0000_0002
`endif

// file: hw/dcf_pkg.sv
// Types for the daisy-chained fault line block
package dcf_pkg;
  // ==========================================
  // Power states
  typedef enum logic [3:0] {
    DCF_NORMAL = 4'b0001,
    DCF_CYCLIC = 4'b0010,
    DCF_SILENT = 4'b0100,
    DCF_SLEEP = 4'b1000
  } dcf_pstate_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } dcf_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } dcf_wb_rsp_t;
endpackage

// file: hw/dcf_level_timer.sv
// Qualifies a level held longer than a programmable limit
`include "dcf_map.svh"
module dcf_level_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic level_i,
  input wire logic [`DCF_CNT_W-1:0] limit_i,
  output logic hit_o
);
  logic [`DCF_CNT_W-1:0] cnt_q;

  // Counts cycles the level holds; restarts whenever it drops or run falls
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || !level_i) begin
      cnt_q <= '0;
    end else if (cnt_q <= limit_i) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Strictly longer than the limit
  assign hit_o = run_i && level_i && (cnt_q > limit_i);
endmodule // dcf_level_timer

// file: hw/dcf_fault_line.sv
// Daisy-chained fault line: output driver, input filter, power-state hooks
// Behaviour
// R1 - Fault logic works in every power state
// R2 - Cyclic: self-detect in on phase; go normal
// R3 - Sleep/silent: propagate only; external fault wakes
// R4 - Normal: fault high, else low or pulses
// R5 - Low power: output low until normal
// R6 - Asserted output holds normal until comm timeout; code holds it only for latched faults, not for the force bit
// R7 - Host clears latches; output then returns inactive
// R8 - Pulses repeat at selected period, fixed width
// R9 - Force bit drives output high
// R10 - Host disables pulses before sleep command
// R11 - Internal fault drives output regardless of input
// R12 - Input qualified only if enabled, not top
// R13 - Host configures top unit receiver off
// R14 - Pulses on: long high sets static flag
// R15 - Pulses on: low 1.2 periods sets loss
// R16 - Otherwise high beyond short time sets static
// R17 - Top unit: internal failures only
// R18 - Qualified upper fault propagates to output
// R19 - Host filters its input the same way
// R20 - Host polls status bits to locate fault
// R21 - Period codes 4, 8, 32, 128 ms
// R22 - Pulse high 500 microseconds
// R23 - Filter switches immediately to short time
// R24 - Input passes two flip-flops first
`include "dcf_map.svh"
module dcf_fault_line (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dcf_pkg::dcf_wb_req_t wb_req_i,
  output dcf_pkg::dcf_wb_rsp_t wb_rsp_o,
  input wire logic fault_in_pin_i,
  output logic fault_out_pin_o,
  input wire logic internal_fault_i,
  input wire logic on_phase_i,
  input wire logic sleep_entry_command_i,
  input wire dcf_pkg::dcf_pstate_t sleep_target_i,
  input wire logic comm_timeout_i,
  output logic wake_request_o,
  output logic global_fault_bit_o,
  output dcf_pkg::dcf_pstate_t power_state_o
);
  import dcf_pkg::*;

  // ==========================================
  // Timing counts
  localparam logic [`DCF_CNT_W-1:0] PulseCyc = `DCF_CNT_W'(`DCF_PULSE_WIDTH_US * `DCF_CLK_MHZ);
  localparam logic [`DCF_CNT_W-1:0] ShortCyc = `DCF_CNT_W'(`DCF_SHORT_FILTER_US * `DCF_CLK_MHZ);
  localparam logic [`DCF_CNT_W-1:0] LongCyc = `DCF_CNT_W'(`DCF_LONG_FILTER_US * `DCF_CLK_MHZ);
  localparam logic [`DCF_CNT_W-1:0] Per0Cyc = `DCF_CNT_W'(`DCF_PERIOD0_MS * `DCF_US_PER_MS * `DCF_CLK_MHZ);
  localparam logic [`DCF_CNT_W-1:0] Per1Cyc = `DCF_CNT_W'(`DCF_PERIOD1_MS * `DCF_US_PER_MS * `DCF_CLK_MHZ);
  localparam logic [`DCF_CNT_W-1:0] Per2Cyc = `DCF_CNT_W'(`DCF_PERIOD2_MS * `DCF_US_PER_MS * `DCF_CLK_MHZ);
  localparam logic [`DCF_CNT_W-1:0] Per3Cyc = `DCF_CNT_W'(`DCF_PERIOD3_MS * `DCF_US_PER_MS * `DCF_CLK_MHZ);

  // ==========================================
  // Registers
  logic [31:0] ctrl_q;
  logic int_latch_q;
  logic ext_latch_q;
  logic static_input_fault_flag_q;
  logic pulse_loss_flag_q;
  logic pulse_train_enable;
  logic fault_receiver_enable;
  logic chain_top_select;
  logic fault_out_force;
  logic [2:0] pulse_period_select;
  dcf_pstate_t pstate_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic in_meta_q;
  logic in_sync_q;
  logic [`DCF_CNT_W-1:0] per_cnt_q;
  logic [`DCF_CNT_W-1:0] period_cyc;
  logic [`DCF_CNT_W-1:0] loss_cyc;
  logic out_q;

  assign pulse_train_enable = ctrl_q[`DCF_CTRL_PTE];
  assign fault_receiver_enable = ctrl_q[`DCF_CTRL_FRE];
  assign chain_top_select = ctrl_q[`DCF_CTRL_TOP];
  assign fault_out_force = ctrl_q[`DCF_CTRL_FORCE];
  assign pulse_period_select = ctrl_q[`DCF_CTRL_PSEL_HI:`DCF_CTRL_PSEL_LO];

  // ==========================================
  // Input synchroniser
  // Only the second flop feeds logic; the first may still be settling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_meta_q <= 1'b0;
      in_sync_q <= 1'b0;
    end else begin
      in_meta_q <= fault_in_pin_i; // R24
      in_sync_q <= in_meta_q; // R24
    end
  end

  // ==========================================
  // Input qualification
  logic rx_on;
  logic in_q;
  logic is_normal;
  logic long_mode;
  logic high_hit_long;
  logic high_hit_short;
  logic low_hit;

  // Top unit overrides the receiver enable
  assign rx_on = fault_receiver_enable && !chain_top_select; // R12 R17
  assign in_q = rx_on ? in_sync_q : 1'b0; // R12
  assign is_normal = (pstate_q == DCF_NORMAL);
  // Filter choice follows the live mode, so a disable or sleep switches it at once
  assign long_mode = is_normal && pulse_train_enable; // R23

  dcf_level_timer u_high_long (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(rx_on && long_mode),
    .level_i(in_q),
    .limit_i(LongCyc),
    .hit_o(high_hit_long)
  ); // R14

  dcf_level_timer u_high_short (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(rx_on && !long_mode),
    .level_i(in_q),
    .limit_i(ShortCyc),
    .hit_o(high_hit_short)
  ); // R16

  // Loss timer shares the long-mode gate: pulses are expected only then
  dcf_level_timer u_low_loss (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(rx_on && long_mode),
    .level_i(!in_q),
    .limit_i(loss_cyc),
    .hit_o(low_hit)
  ); // R15

  logic ext_event;
  logic int_event;
  assign ext_event = high_hit_long || high_hit_short || low_hit; // R18
  // Cyclic wakeup self-detects only while on; sleep and silent never
  assign int_event = internal_fault_i && (is_normal || (pstate_q == DCF_CYCLIC && on_phase_i)); // R2 R3 R11

  // ==========================================
  // Read words
  logic [1:0] pstate_code;
  logic [31:0] ctrl_word;
  logic [31:0] fail_word;
  logic [31:0] stat_word;

  // Two-bit state code seen by software
  always_comb begin
    case (pstate_q)
      DCF_CYCLIC: pstate_code = `DCF_PCODE_CYCLIC;
      DCF_NORMAL: pstate_code = `DCF_PCODE_NORMAL;
      DCF_SILENT: pstate_code = `DCF_PCODE_SILENT;
      DCF_SLEEP: pstate_code = `DCF_PCODE_SLEEP;
      default: pstate_code = `DCF_PCODE_NORMAL;
    endcase
  end

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`DCF_CTRL_PSEL_HI:0] = ctrl_q[`DCF_CTRL_PSEL_HI:0];
    fail_word = '0;
    fail_word[`DCF_FAIL_INT] = int_latch_q;
    fail_word[`DCF_FAIL_EXT] = ext_latch_q;
    stat_word = '0;
    stat_word[`DCF_STAT_STATIC] = static_input_fault_flag_q;
    stat_word[`DCF_STAT_LOSS] = pulse_loss_flag_q;
    stat_word[`DCF_STAT_OUT] = out_q;
    stat_word[`DCF_STAT_IN] = in_sync_q;
    stat_word[`DCF_STAT_PST_HI:`DCF_STAT_PST_LO] = pstate_code;
  end

  // ==========================================
  // Bus slave
  logic [`DCF_ADDR_W-1:0] wb_addr;
  logic wb_hit;
  logic wb_commit;
  logic wr_ctrl;
  logic wr_fail;
  logic wr_stat;
  assign wb_addr = wb_req_i.adr[`DCF_ADDR_W-1:0];
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  // Writes land at the edge where the master sees ack, so both sides agree on the moment
  assign wb_commit = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && ack_q;
  assign wr_ctrl = wb_commit && (wb_addr == `DCF_ADDR_CTRL);
  assign wr_fail = wb_commit && wb_req_i.sel[0] && (wb_addr == `DCF_ADDR_FAIL);
  assign wr_stat = wb_commit && wb_req_i.sel[0] && (wb_addr == `DCF_ADDR_STAT);

  // One registered ack per request, a cycle after it; dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `DCF_CTRL_RST;
    end else if (wr_ctrl) begin
      for (int i = 0; i < `DCF_LANES; i++) begin
        if (wb_req_i.sel[i]) begin
          ctrl_q[i*`DCF_LANE_W +: `DCF_LANE_W] <= wb_req_i.dat[i*`DCF_LANE_W +: `DCF_LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (wb_hit && !wb_req_i.we) begin
      case (wb_addr)
        `DCF_ADDR_CTRL: rdat_q <= ctrl_word;
        `DCF_ADDR_FAIL: rdat_q <= fail_word;
        `DCF_ADDR_STAT: rdat_q <= stat_word;
        default: rdat_q <= '0;
      endcase
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;

  // ==========================================
  // Fault latches: write one to clear, a new event wins
  // Both latches keep the output high while the state is normal, until software clears them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_latch_q <= 1'b0;
      ext_latch_q <= 1'b0;
    end else begin
      int_latch_q <= int_event || (int_latch_q && !(wr_fail && wb_req_i.dat[`DCF_FAIL_INT])); // R7 R11
      ext_latch_q <= ext_event || (ext_latch_q && !(wr_fail && wb_req_i.dat[`DCF_FAIL_EXT])); // R7 R18
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      static_input_fault_flag_q <= 1'b0;
      pulse_loss_flag_q <= 1'b0;
    end else begin
      static_input_fault_flag_q <= high_hit_long || high_hit_short ||
        (static_input_fault_flag_q && !(wr_stat && wb_req_i.dat[`DCF_STAT_STATIC])); // R14 R16
      pulse_loss_flag_q <= low_hit ||
        (pulse_loss_flag_q && !(wr_stat && wb_req_i.dat[`DCF_STAT_LOSS])); // R15
    end
  end

  // ==========================================
  // Power state
  logic any_fault;
  assign any_fault = int_latch_q || ext_latch_q;

  // Enum default recovers an illegal code to normal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pstate_q <= DCF_NORMAL;
    end else begin
      case (pstate_q)
        DCF_NORMAL: begin
          // Timeout may still force low power while a fault stands
          if (sleep_entry_command_i && (!any_fault || comm_timeout_i)) begin // R6
            pstate_q <= sleep_target_i;
          end
        end
        DCF_CYCLIC: begin
          if (int_event || ext_event) begin // R2
            pstate_q <= DCF_NORMAL;
          end
        end
        DCF_SILENT, DCF_SLEEP: begin
          if (ext_event) begin // R3
            pstate_q <= DCF_NORMAL;
          end
        end
        default: pstate_q <= DCF_NORMAL;
      endcase
    end
  end

  assign power_state_o = pstate_q; // R1
  // Combinational so a wake costs no extra cycle
  assign wake_request_o = !is_normal && (ext_event || int_event);
  assign global_fault_bit_o = int_latch_q;

  // ==========================================
  // Pulse train
  // Reserved codes fall back to the shortest period
  always_comb begin
    case (pulse_period_select) // R21
      3'h0: period_cyc = Per0Cyc;
      3'h1: period_cyc = Per1Cyc;
      3'h2: period_cyc = Per2Cyc;
      3'h3: period_cyc = Per3Cyc;
      default: period_cyc = Per0Cyc;
    endcase
  end

  // Loss limit; largest value fits in 32 bits
  assign loss_cyc = `DCF_CNT_W'((64'(period_cyc) * `DCF_LOSS_NUM) / `DCF_LOSS_DEN); // R15

  // Counter rests at zero outside normal so the first pulse starts at once
  always_ff @(posedge clk_i) begin
    if (rst_i || !pulse_train_enable || !is_normal) begin
      per_cnt_q <= '0;
    end else if (per_cnt_q >= period_cyc - 1'b1) begin
      per_cnt_q <= '0; // R8
    end else begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  logic pulse_phase;
  assign pulse_phase = (per_cnt_q < PulseCyc); // R22

  // ==========================================
  // Output driver
  // Force and latched faults override the pulse train
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else if (!is_normal) begin
      out_q <= 1'b0; // R5
    end else if (any_fault || fault_out_force) begin
      out_q <= 1'b1; // R4 R6 R9
    end else if (pulse_train_enable) begin
      out_q <= pulse_phase; // R8 R22
    end else begin
      out_q <= 1'b0; // R4 R7
    end
  end

  assign fault_out_pin_o = out_q;
endmodule // dcf_fault_line

// file: tb/dcf_fault_line_checker.sv
// Port checker for the fault line block
module dcf_fault_line_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dcf_pkg::dcf_wb_req_t wb_req_i,
  input wire dcf_pkg::dcf_wb_rsp_t wb_rsp_o,
  input wire logic fault_in_pin_i,
  input wire logic fault_out_pin_o,
  input wire logic internal_fault_i,
  input wire logic on_phase_i,
  input wire logic sleep_entry_command_i,
  input wire dcf_pkg::dcf_pstate_t sleep_target_i,
  input wire logic comm_timeout_i,
  input wire logic wake_request_o,
  input wire logic global_fault_bit_o,
  input wire dcf_pkg::dcf_pstate_t power_state_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import dcf_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Bus handshake
  ack_follows_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not acked");
  ack_single_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_req_i.cyc && wb_req_i.stb) |=> !wb_rsp_o.ack)
    else $error("ack without request");
  // ==========================================
  // Fault line
  self_fault_a: assert property (internal_fault_i && power_state_o == DCF_NORMAL |-> ##[1:3] fault_out_pin_o)
    else $error("internal fault not driven out");
  fault_latch_a: assert property (internal_fault_i && power_state_o == DCF_NORMAL |-> ##[0:2] global_fault_bit_o)
    else $error("internal fault not latched");
  // Allow one cycle for the registered output to follow the state change
  low_power_quiet_a: assert property (power_state_o != DCF_NORMAL && $past(power_state_o) != DCF_NORMAL |-> !fault_out_pin_o)
    else $error("output high in low power");
  hold_normal_a: assert property (global_fault_bit_o && !comm_timeout_i && power_state_o == DCF_NORMAL
    |=> power_state_o == DCF_NORMAL)
    else $error("left normal while faulted");
  wake_normal_a: assert property (wake_request_o |-> ##[1:2] power_state_o == DCF_NORMAL)
    else $error("wake did not reach normal");
endmodule // dcf_fault_line_checker

// file: tb/dcf_upper_unit.sv
// Model of the unit above, driving its fault output down the chain
module dcf_upper_unit (
  input wire logic clk_i,
  input wire logic fail_i,
  output logic fault_out_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lvl_q = 1'b0;
  // Static level mode with pulses off, so an idle line rests low
  always @(posedge clk_i) begin
    lvl_q <= fail_i;
  end
  assign fault_out_pin_o = lvl_q;
endmodule // dcf_upper_unit

// file: tb/dcf_fault_line_test.sv
// Testbench for the fault line block
module test_dcf_fault_line;
  timeunit 1ns;
  timeprecision 100ps;
  import dcf_pkg::*;
  logic clk_i, rst_i, up_fail, pin, out, intf, onp, cmd, cto, wake, gbit;
  dcf_wb_req_t req;
  dcf_wb_rsp_t rsp;
  dcf_pstate_t tgt, pst;
  logic [31:0] rd;
  int err_total, check_count;
  always #2 clk_i = ~clk_i;
  dcf_upper_unit upper (.clk_i(clk_i), .fail_i(up_fail), .fault_out_pin_o(pin));
  dcf_fault_line dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .fault_in_pin_i(pin),
    .fault_out_pin_o(out), .internal_fault_i(intf), .on_phase_i(onp), .sleep_entry_command_i(cmd),
    .sleep_target_i(tgt), .comm_timeout_i(cto), .wake_request_o(wake), .global_fault_bit_o(gbit),
    .power_state_o(pst));
  // ==========================================
  // Shared tasks
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic stall();
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chb(input logic exp);
    chk({31'h0, out}, {31'h0, exp});
  endtask
  task automatic chs(input dcf_pstate_t s);
    chk({28'h0, pst}, {28'h0, s});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Holds the request until ack is sampled, then idles one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{adr: {24'h0, a}, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    @(posedge clk_i);
    while (rsp.ack !== 1'b1) begin
      n++;
      if (n > 50) stall();
      @(posedge clk_i);
    end
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask
  // Pulses are never on before a sleep command, so the disable lead always holds
  task automatic go(input dcf_pstate_t s);
    cmd <= 1'b1;
    tgt <= s;
    @(posedge clk_i);
    cmd <= 1'b0;
    tick(2);
  endtask
  task automatic wait_state(input dcf_pstate_t s, input int lim);
    int n;
    n = 0;
    while (pst !== s) begin
      n++;
      if (n > lim) stall();
      @(posedge clk_i);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    wb(0, 8'h00, 0);
    chk(rd, 32'h0000_0002);
    wb(0, 8'h10, 0);
    chk(rd, 32'h0);
    chb(1'b0);
    chs(DCF_NORMAL);
  endtask
  task automatic t_internal();
    intf <= 1'b1;
    tick(4);
    chb(1'b1);
    chk({31'h0, gbit}, 32'h1);
    wb(0, 8'h04, 0);
    chk(rd, 32'h1);
    go(DCF_SLEEP);
    chs(DCF_NORMAL);
    intf <= 1'b0;
    wb(1, 8'h04, 32'h1);
    tick(3);
    chb(1'b0);
  endtask
  task automatic t_force_pulse();
    wb(1, 8'h00, 32'hc);
    tick(3);
    chb(1'b1);
    wb(1, 8'h00, 32'h3);
    tick(3);
    chb(1'b1);
    tick(200);
    chb(1'b1);
    wb(1, 8'h00, 32'h2);
    tick(3);
    chb(1'b0);
  endtask
  task automatic t_cyclic();
    go(DCF_CYCLIC);
    onp <= 1'b0;
    intf <= 1'b1;
    tick(5);
    chs(DCF_CYCLIC);
    chb(1'b0);
    onp <= 1'b1;
    @(posedge clk_i);
    chk({31'h0, wake}, 32'h1);
    wait_state(DCF_NORMAL, 5);
    tick(3);
    chb(1'b1);
    intf <= 1'b0;
    onp <= 1'b0;
    wb(1, 8'h04, 32'h1);
  endtask
  task automatic t_sleep();
    go(DCF_SLEEP);
    up_fail <= 1'b1;
    tick(70000);
    chs(DCF_SLEEP);
    wait_state(DCF_NORMAL, 10000);
    tick(3);
    chb(1'b1);
    wb(0, 8'h08, 0);
    chk(rd & 32'h3, 32'h1);
    up_fail <= 1'b0;
    tick(6);
    wb(1, 8'h08, 32'h1);
    wb(1, 8'h04, 32'h2);
    tick(3);
    chb(1'b0);
    go(DCF_SILENT);
    intf <= 1'b1;
    tick(10);
    chs(DCF_SILENT);
    chb(1'b0);
  endtask
  // Mid-run reset out of silent balancing, with force set and a fault pending
  task automatic t_rerun();
    wb(1, 8'h00, 32'h8);
    chb(1'b0);
    rst_i <= 1'b1;
    intf <= 1'b0;
    tick(3);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chs(DCF_NORMAL);
    chb(1'b0);
    wb(0, 8'h00, 0);
    chk(rd, 32'h0000_0002);
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    req = '0;
    {up_fail, intf, onp, cmd, cto} = 5'h0;
    tgt = DCF_NORMAL;
    err_total = 0;
    check_count = 0;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    t_reset();
    t_internal();
    t_cyclic();
    t_sleep();
    t_rerun();
    t_force_pulse();
    wrap_up();
  end
endmodule // test_dcf_fault_line
bind dcf_fault_line dcf_fault_line_checker chk_u (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .fault_in_pin_i,
  .fault_out_pin_o, .internal_fault_i, .on_phase_i, .sleep_entry_command_i, .sleep_target_i, .comm_timeout_i,
  .wake_request_o, .global_fault_bit_o, .power_state_o);
